// ### cmpd_cfg.svh
// constants for the class-mode pin default bank: offsets, fields, codes
// assumes inclusion by every file of the bank that uses its macros, before any module
`ifndef CMPD_CFG_SVH
`define CMPD_CFG_SVH

// register offsets on the byte register port
`define CMPD_OFF_MODE_LOW   12'h009
`define CMPD_OFF_MODE_HIGH  12'h00a
`define CMPD_OFF_DIR_LOW    12'h00b
`define CMPD_OFF_DIR_HIGH   12'h00c
`define CMPD_OFF_MASK_LOW   12'h00d
`define CMPD_OFF_MASK_HIGH  12'h00e
`define CMPD_OFF_THR_0      12'h00f
`define CMPD_OFF_THR_1      12'h010
`define CMPD_OFF_THR_2      12'h011

// storage slots inside the register memory
`define CMPD_IDX_MODE_LOW   4'h0
`define CMPD_IDX_MODE_HIGH  4'h1
`define CMPD_IDX_DIR_LOW    4'h2
`define CMPD_IDX_DIR_HIGH   4'h3
`define CMPD_IDX_MASK_LOW   4'h4
`define CMPD_IDX_MASK_HIGH  4'h5
`define CMPD_IDX_THR_0      4'h6
`define CMPD_IDX_THR_1      4'h7
`define CMPD_IDX_THR_2      4'h8
`define CMPD_NUM_REGS       9

// reset values
`define CMPD_RST_MODE_HIGH  8'h03
`define CMPD_RST_ZERO       8'h00

// writable bits; reserved bits stay zero
`define CMPD_WMASK_FULL     8'hff
`define CMPD_WMASK_HIGH2    8'h03
`define CMPD_WMASK_HIGH3    8'h07

// low mode byte fields
`define CMPD_BIT_CLK_EN     7
`define CMPD_SEC_HI         6
`define CMPD_SEC_LO         5
`define CMPD_BIT_PIN_SEL    4
`define CMPD_BIT_POL        3
`define CMPD_MODE_HI        2
`define CMPD_MODE_LO        0

// high mode byte and high mask byte fields
`define CMPD_BIT_RX_TOG     1
`define CMPD_BIT_TX_TOG     0
`define CMPD_BIT_RX_MASK    2

// secondary pin select codes
`define CMPD_SEC_GPIO       2'b00
`define CMPD_SEC_SEND       2'b01
`define CMPD_SEC_MATCH      2'b10

// request-to-send pin mode codes
`define CMPD_MODE_GPIO      3'b000
`define CMPD_MODE_RTS_CTS   3'b001
`define CMPD_MODE_DTR_DSR   3'b010
`define CMPD_MODE_SEND      3'b011
`define CMPD_MODE_MATCH     3'b100

// general pin numbers
`define CMPD_PIN_DTR        2
`define CMPD_PIN_DSR        3
`define CMPD_PIN_CTS        4
`define CMPD_PIN_RTS        5
`define CMPD_PIN_CLK        6
`define CMPD_PIN_SEC        7
`define CMPD_PIN_TXT        8
`define CMPD_PIN_RXT        9
`define CMPD_NUM_PINS       10

// clock output half period in core cycles
`define CMPD_CLK_HALF       16'h0004

`endif

// ### cmpd_pkg.sv
// shared types and helpers of the class-mode pin default bank
// assumes cmpd_cfg.svh is found on the include path
`include "cmpd_cfg.svh"

package cmpd_pkg;

	typedef logic [7:0] cmpd_byte_t;
	typedef logic [`CMPD_NUM_PINS-1:0] cmpd_pins_t;

	// ten-bit vector from a full low byte and two high bits
	function automatic cmpd_pins_t cmpd_join10(input cmpd_byte_t low,
		input cmpd_byte_t high);
		cmpd_join10 = {high[1:0], low};
	endfunction

	// half-duplex enable level, optionally inverted
	function automatic logic cmpd_dir_level(input logic active,
		input logic invert);
		cmpd_dir_level = active ^ invert;
	endfunction

endpackage

// ### cmpd_sync.sv
// three-stage synchroniser for pin inputs
// a change is taken once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module cmpd_sync #(
	parameter int WIDTH = 11
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] raw_in,
	output logic      [WIDTH-1:0] stable_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] stable;
	} cmpd_sync_t;

	cmpd_sync_t q;
	cmpd_sync_t next_q;

	always_comb begin
		next_q = q;
		next_q.s1 = raw_in;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				next_q.stable[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			next_q_reset: q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign stable_out = q.stable;

endmodule // cmpd_sync

`default_nettype wire

// ### cmpd_regfile.sv
// nine-byte default register store with registered read data
// assumes the caller decodes the address into a slot and a hit
`timescale 1ns/1ps
`default_nettype none
`include "cmpd_cfg.svh"

module cmpd_regfile
	import cmpd_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic       hit,
	input  wire logic [3:0] slot,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	output logic      [`CMPD_NUM_REGS*8-1:0] contents
);

	typedef struct packed {
		logic [`CMPD_NUM_REGS-1:0][7:0] mem;
		logic [7:0]                     rdata;
	} cmpd_regfile_t;

	cmpd_regfile_t q;
	cmpd_regfile_t next_q;

	// reserved bits are never stored, so they always read zero
	function automatic cmpd_byte_t wmask(input logic [3:0] s);
		if (s == `CMPD_IDX_MODE_HIGH || s == `CMPD_IDX_DIR_HIGH) begin
			wmask = `CMPD_WMASK_HIGH2;
		end else if (s == `CMPD_IDX_MASK_HIGH) begin
			wmask = `CMPD_WMASK_HIGH3;
		end else begin
			wmask = `CMPD_WMASK_FULL;
		end
	endfunction

	always_comb begin
		next_q = q;
		if (wr_en && hit) begin
			next_q.mem[slot] = wdata & wmask(slot);
		end
		if (rd_en) begin
			next_q.rdata = hit ? q.mem[slot] : `CMPD_RST_ZERO;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			q.mem[`CMPD_IDX_MODE_HIGH] <= `CMPD_RST_MODE_HIGH;
		end else begin
			q <= next_q;
		end
	end

	assign rdata    = q.rdata;
	assign contents = q.mem;

endmodule // cmpd_regfile

`default_nettype wire

// ### cmpd_top.sv
// class-mode pin default bank: registers, pin function muxing, change events
// assumes a byte register port from the core, raw pins from the far side
//
// Overview of operation
// - a set clock-enable bit turns general pin six into a clock output.
// - the secondary select codes give general I/O, send enable or match.
// - pin-select clear leaves the secondary pin general, set lets it work.
// - the mode field picks general I/O, two flow controls or two enables.
// - receive-activity toggle drives general pin nine when enabled.
// - transmit-activity toggle drives general pin eight when enabled.
// - a ten-bit vector sets each general pin input (0) or output (1).
// - an unmasked general input that changes requests an event packet.
// - high mask bit two gates change events on the receive data input.
// - three threshold bytes assemble the 24-bit low-latency threshold.
// - each default group applies only while its override enable is clear.
`timescale 1ns/1ps
`default_nettype none
`include "cmpd_cfg.svh"

module cmpd_top
	import cmpd_pkg::*;
#(
	parameter logic [15:0] CLK_HALF      = `CMPD_CLK_HALF,
	parameter logic [7:0]  DEF_MODE_LOW  = 8'h00,
	parameter logic [7:0]  DEF_MODE_HIGH = 8'h03,
	parameter logic [9:0]  DEF_DIR       = 10'h000,
	parameter logic [10:0] DEF_MASK      = 11'h000,
	parameter logic [23:0] DEF_THRESH    = 24'h000000
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// byte register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// override enables of each default group
	input  wire logic        override_mode,
	input  wire logic        override_direction,
	input  wire logic        override_mask,
	input  wire logic        override_threshold,
	// uart side
	input  wire logic        uart_sending,
	input  wire logic        address_matched,
	input  wire logic        rx_has_room,
	input  wire logic        tx_char_done,
	input  wire logic        rx_char_done,
	output logic             tx_allowed,
	output logic      [23:0] latency_baud_threshold,
	// host-driven general output levels and sampled pin states
	input  wire logic [9:0]  gpio_write,
	output logic      [9:0]  gpio_state,
	// change event toward the class interrupt packet builder
	output logic             change_event,
	output logic      [10:0] change_bits,
	// pins
	input  wire logic [9:0]  pin_in,
	input  wire logic        rx_data_pin,
	output logic      [9:0]  pin_out,
	output logic      [9:0]  pin_oe
);

	////////////////////////////////////////////////////////////////////////
	// register store

	logic [3:0]                    slot;
	logic                          hit;
	logic [`CMPD_NUM_REGS*8-1:0]   contents;
	logic [`CMPD_NUM_REGS-1:0][7:0] regs;

	always_comb begin
		hit  = 1'b1;
		slot = `CMPD_IDX_MODE_LOW;
		if (reg_addr == `CMPD_OFF_MODE_LOW) begin
			slot = `CMPD_IDX_MODE_LOW;
		end else if (reg_addr == `CMPD_OFF_MODE_HIGH) begin
			slot = `CMPD_IDX_MODE_HIGH;
		end else if (reg_addr == `CMPD_OFF_DIR_LOW) begin
			slot = `CMPD_IDX_DIR_LOW;
		end else if (reg_addr == `CMPD_OFF_DIR_HIGH) begin
			slot = `CMPD_IDX_DIR_HIGH;
		end else if (reg_addr == `CMPD_OFF_MASK_LOW) begin
			slot = `CMPD_IDX_MASK_LOW;
		end else if (reg_addr == `CMPD_OFF_MASK_HIGH) begin
			slot = `CMPD_IDX_MASK_HIGH;
		end else if (reg_addr == `CMPD_OFF_THR_0) begin
			slot = `CMPD_IDX_THR_0;
		end else if (reg_addr == `CMPD_OFF_THR_1) begin
			slot = `CMPD_IDX_THR_1;
		end else if (reg_addr == `CMPD_OFF_THR_2) begin
			slot = `CMPD_IDX_THR_2;
		end else begin
			hit = 1'b0;
		end
	end

	cmpd_regfile u_regfile (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.wr_en    (reg_wr),
		.rd_en    (reg_rd),
		.hit      (hit),
		.slot     (slot),
		.wdata    (reg_wdata),
		.rdata    (reg_rdata),
		.contents (contents)
	);

	assign regs = contents;

	////////////////////////////////////////////////////////////////////////
	// pin input synchronisers

	logic [10:0] sampled;

	cmpd_sync #(
		.WIDTH (11)
	) u_sync (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.raw_in     ({rx_data_pin, pin_in}),
		.stable_out (sampled)
	);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0] clk_cnt;
		logic        clk_level;
		logic        tx_toggle;
		logic        rx_toggle;
		logic [10:0] prev;
		logic        event_pulse;
		logic [10:0] event_bits;
		logic [9:0]  pin_out;
		logic [9:0]  pin_oe;
		logic        tx_allowed;
		logic [23:0] threshold;
	} cmpd_state_t;

	cmpd_state_t q;
	cmpd_state_t next_q;

	////////////////////////////////////////////////////////////////////////
	// effective configuration and next state

	logic [7:0]  mode_low;
	logic [7:0]  mode_high;
	logic [9:0]  dir;
	logic [10:0] mask;
	logic [1:0]  sec_sel;
	logic [2:0]  mode_sel;
	logic        invert;
	logic [9:0]  claim;
	logic [9:0]  fn_out;
	logic [9:0]  fn_in;
	logic [10:0] watch;
	logic [10:0] changed;

	always_comb begin
		next_q = q;

		// built-in class defaults unless overridden
		mode_low  = override_mode ? regs[`CMPD_IDX_MODE_LOW] : DEF_MODE_LOW;
		mode_high = override_mode ? regs[`CMPD_IDX_MODE_HIGH]
			: DEF_MODE_HIGH;
		dir = override_direction ? cmpd_join10(regs[`CMPD_IDX_DIR_LOW],
			regs[`CMPD_IDX_DIR_HIGH]) : DEF_DIR;
		mask = override_mask ? {regs[`CMPD_IDX_MASK_HIGH][`CMPD_BIT_RX_MASK],
			cmpd_join10(regs[`CMPD_IDX_MASK_LOW],
			regs[`CMPD_IDX_MASK_HIGH])} : DEF_MASK;
		next_q.threshold = override_threshold ? {regs[`CMPD_IDX_THR_2],
			regs[`CMPD_IDX_THR_1], regs[`CMPD_IDX_THR_0]}
			: DEF_THRESH;

		sec_sel  = mode_low[`CMPD_SEC_HI:`CMPD_SEC_LO];
		mode_sel = mode_low[`CMPD_MODE_HI:`CMPD_MODE_LO];
		invert   = mode_low[`CMPD_BIT_POL];
		claim    = '0;
		fn_out   = '0;
		fn_in    = '0;

		// clock output; divider stops and parks low when disabled
		if (mode_low[`CMPD_BIT_CLK_EN]) begin
			if (q.clk_cnt >= CLK_HALF - 16'h0001) begin
				next_q.clk_cnt   = '0;
				next_q.clk_level = ~q.clk_level;
			end else begin
				next_q.clk_cnt = q.clk_cnt + 16'h0001;
			end
			claim[`CMPD_PIN_CLK]  = 1'b1;
			fn_out[`CMPD_PIN_CLK] = q.clk_level;
		end else begin
			next_q.clk_cnt   = '0;
			next_q.clk_level = 1'b0;
		end

		// request-to-send pin function
		case (mode_sel)
			`CMPD_MODE_RTS_CTS: begin
				claim[`CMPD_PIN_RTS]  = 1'b1;
				fn_out[`CMPD_PIN_RTS] = ~rx_has_room; // active-low request
				fn_in[`CMPD_PIN_CTS]  = 1'b1;
			end
			`CMPD_MODE_DTR_DSR: begin
				claim[`CMPD_PIN_DTR]  = 1'b1;
				fn_out[`CMPD_PIN_DTR] = ~rx_has_room;
				fn_in[`CMPD_PIN_DSR]  = 1'b1;
			end
			`CMPD_MODE_SEND: begin
				claim[`CMPD_PIN_RTS]  = 1'b1;
				fn_out[`CMPD_PIN_RTS] = cmpd_dir_level(uart_sending, invert);
			end
			`CMPD_MODE_MATCH: begin
				claim[`CMPD_PIN_RTS]  = 1'b1;
				fn_out[`CMPD_PIN_RTS] = cmpd_dir_level(address_matched,
					invert);
			end
			default: begin
				// general I/O, reserved codes behave the same
			end
		endcase

		// secondary pin only leaves general I/O when selected
		if (mode_low[`CMPD_BIT_PIN_SEL]) begin
			case (sec_sel)
				`CMPD_SEC_SEND: begin
					claim[`CMPD_PIN_SEC]  = 1'b1;
					fn_out[`CMPD_PIN_SEC] = cmpd_dir_level(uart_sending,
						invert);
				end
				`CMPD_SEC_MATCH: begin
					claim[`CMPD_PIN_SEC]  = 1'b1;
					fn_out[`CMPD_PIN_SEC] = cmpd_dir_level(address_matched,
						invert);
				end
				default: begin
					// general I/O, reserved code behaves the same
				end
			endcase
		end

		// activity toggles flip once per character
		if (tx_char_done) begin
			next_q.tx_toggle = ~q.tx_toggle;
		end
		if (rx_char_done) begin
			next_q.rx_toggle = ~q.rx_toggle;
		end
		if (mode_high[`CMPD_BIT_TX_TOG]) begin
			claim[`CMPD_PIN_TXT]  = 1'b1;
			fn_out[`CMPD_PIN_TXT] = q.tx_toggle;
		end
		if (mode_high[`CMPD_BIT_RX_TOG]) begin
			claim[`CMPD_PIN_RXT]  = 1'b1;
			fn_out[`CMPD_PIN_RXT] = q.rx_toggle;
		end

		// flow inputs are active low; no flow mode means always clear
		if (fn_in[`CMPD_PIN_CTS]) begin
			next_q.tx_allowed = ~sampled[`CMPD_PIN_CTS];
		end else if (fn_in[`CMPD_PIN_DSR]) begin
			next_q.tx_allowed = ~sampled[`CMPD_PIN_DSR];
		end else begin
			next_q.tx_allowed = 1'b1;
		end

		// function outputs drive, function inputs stay inputs; the rest follow the direction vector
		next_q.pin_oe  = claim | (dir & ~fn_in);
		next_q.pin_out = (claim & fn_out) | (~claim & gpio_write);

		// change events on general inputs and the receive data line
		watch   = {1'b1, ~dir & ~claim};
		changed = (sampled ^ q.prev) & watch & ~mask;
		next_q.prev        = sampled;
		next_q.event_pulse = |changed;
		next_q.event_bits  = changed;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			q.tx_allowed <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// sampled levels are used for both events and state reads
	assign gpio_state             = sampled[9:0];
	assign tx_allowed             = q.tx_allowed;
	assign latency_baud_threshold = q.threshold;
	assign change_event           = q.event_pulse;
	assign change_bits            = q.event_bits;
	assign pin_out                = q.pin_out;
	assign pin_oe                 = q.pin_oe;

endmodule // cmpd_top

`default_nettype wire

// ### cmpd_chk.sv
// checker of the class-mode pin default bank, bound to its top module
// assumes it sees the top ports only; shadows register writes itself
`timescale 1ns/1ps
`default_nettype none

module cmpd_chk
	import cmpd_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        reg_wr,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        override_mode,
	input wire logic        override_direction,
	input wire logic        override_mask,
	input wire logic        override_threshold,
	input wire logic        uart_sending,
	input wire logic        address_matched,
	input wire logic        rx_has_room,
	input wire logic        tx_char_done,
	input wire logic [23:0] latency_baud_threshold,
	input wire logic        change_event,
	input wire logic [10:0] change_bits,
	input wire logic [9:0]  pin_out,
	input wire logic [9:0]  pin_oe
);
	logic [7:0] sh [9];

	// reserved bits are dropped so the shadow matches stored values
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < 9; i++)
				sh[i] <= (i == 1) ? 8'h03 : 8'h00;
		end else if (reg_wr && reg_addr >= 12'h009 && reg_addr <= 12'h011) begin
			sh[reg_addr - 12'h009] <= reg_wdata
				& ((reg_addr == 12'h00a || reg_addr == 12'h00c) ? 8'h03 :
				(reg_addr == 12'h00e) ? 8'h07 : 8'hff);
		end
	end

	wire logic [7:0]  ml = override_mode ? sh[0] : 8'h00;
	wire logic [7:0]  mh = override_mode ? sh[1] : 8'h03;
	wire logic [7:0]  dl = override_direction ? sh[2] : 8'h00;
	wire logic [10:0] mk = override_mask ? {sh[5][2:0], sh[4]} : 11'h000;
	wire logic [23:0] th = override_threshold ? {sh[8], sh[7], sh[6]}
		: 24'h000000;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_clk_pin_out: assert property (ml[7] |=> pin_oe[6])
		else $error("clock pin not driven");
	a_sec_send_en: assert property (ml[4] && ml[6:5] == 2'b01 |=>
		pin_oe[7] && pin_out[7] == ($past(uart_sending) ^ $past(ml[3])))
		else $error("secondary send enable wrong");
	a_match_en_out: assert property (ml[2:0] == 3'b100 |=>
		pin_oe[5] && pin_out[5] == ($past(address_matched) ^ $past(ml[3])))
		else $error("match enable wrong");
	a_rts_flow_out: assert property (ml[2:0] == 3'b001 |=>
		pin_oe[5] && !pin_oe[4] && pin_out[5] == !$past(rx_has_room))
		else $error("request pin wrong");
	a_tx_toggle_flip: assert property (mh[0] && tx_char_done ##1
		mh[0] |=> pin_out[8] != $past(pin_out[8]))
		else $error("tx toggle missed");
	a_dir_low_pins: assert property (1'b1 |=>
		pin_oe[1:0] == $past(dl[1:0]))
		else $error("pin direction wrong");
	a_mask_gate_bits: assert property (change_event |->
		(change_bits & (mk | $past(mk))) == 11'h000)
		else $error("masked change reported");
	a_bits_quiet_idle: assert property (!change_event |->
		change_bits == 11'h000)
		else $error("change bits without event");
	a_thresh_value: assert property (1'b1 |=>
		latency_baud_threshold == $past(th))
		else $error("threshold wrong");
endmodule // cmpd_chk

bind cmpd_top cmpd_chk u_chk (.sys_clk, .rst, .reg_wr, .reg_addr,
	.reg_wdata, .override_mode, .override_direction, .override_mask,
	.override_threshold, .uart_sending, .address_matched, .rx_has_room,
	.tx_char_done, .latency_baud_threshold, .change_event, .change_bits,
	.pin_out, .pin_oe);

`default_nettype wire

// ### cmpd_far.sv
// far-side model: the ten general pins and what stands on them
// assumes the bench commands the level of every pin nobody drives
`timescale 1ns/1ps
`default_nettype none

module cmpd_far (
	input  wire logic [9:0] pin_out,
	input  wire logic [9:0] pin_oe,
	input  wire logic [9:0] ext_lvl,
	output logic      [9:0] pin_in
);
	// a driven pin reads back its own level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // cmpd_far

`default_nettype wire

// ### tb_top.sv
// self-checking bench of the class-mode pin default bank
// assumes cmpd_top, cmpd_far and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top;
	logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic override_mode = 0, override_direction = 0;
	logic override_mask = 0, override_threshold = 0;
	logic uart_sending = 0, address_matched = 0, rx_has_room = 1;
	logic tx_char_done = 0, rx_char_done = 0, rx_data_pin = 0;
	logic [11:0] reg_addr = 0;
	logic [7:0]  reg_wdata = 0, n_ev = 0;
	logic [9:0]  gpio_write = 0, ext_lvl = 0;
	logic [10:0] ev_bits = 0;
	wire logic [7:0]  reg_rdata;
	wire logic        tx_allowed, change_event;
	wire logic [23:0] latency_baud_threshold;
	wire logic [10:0] change_bits;
	wire logic [9:0]  pin_in, pin_out, pin_oe, gpio_state;
	int mismatches = 0, n_tests = 0, cyc_n = 0;

	cmpd_top #(.CLK_HALF(16'h0003)) u_dut (.sys_clk, .rst, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .override_mode,
		.override_direction, .override_mask, .override_threshold,
		.uart_sending, .address_matched, .rx_has_room, .tx_char_done,
		.rx_char_done, .tx_allowed, .latency_baud_threshold, .gpio_write,
		.gpio_state, .change_event, .change_bits, .pin_in, .rx_data_pin,
		.pin_out, .pin_oe);
	cmpd_far u_far (.pin_out, .pin_oe, .ext_lvl, .pin_in);

	initial begin
		forever #4 sys_clk = ~sys_clk;
	end

	// falling edge: the pulse is settled, no race with its launch edge
	always @(negedge sys_clk) begin
		if (change_event === 1'b1) begin
			n_ev <= n_ev + 8'h01;
			ev_bits <= ev_bits | change_bits;
		end
	end

	always @(posedge sys_clk) begin
		cyc_n++;
		// far above the few hundred cycles the run needs
		if (cyc_n == 20000) begin
			mismatches++;
			summarize;
		end
	end

	task automatic summarize;
		$display("tests=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		for (logic [11:0] a = 12'h009; a <= 12'h011; a++)
			rd(a, (a == 12'h00a) ? 8'h03 : 8'h00);
		wr(12'h012, 8'h5a);
		rd(12'h012, 8'h00);
		// reserved bits written on purpose to see them refused
		for (logic [11:0] a = 12'h009; a <= 12'h011; a++) begin
			wr(a, 8'hff);
			rd(a, (a == 12'h00a || a == 12'h00c) ? 8'h03 :
				(a == 12'h00e) ? 8'h07 : 8'hff);
		end
		for (logic [11:0] a = 12'h009; a <= 12'h011; a++)
			wr(a, 8'h00);
	endtask

	task automatic t_thresh;
		@(posedge sys_clk) override_threshold <= 1;
		wr(12'h00f, 8'h12);
		wr(12'h010, 8'h34);
		wr(12'h011, 8'h56);
		cyc(2);
		`CHK(latency_baud_threshold, 24'h563412)
		@(posedge sys_clk) override_threshold <= 0;
		cyc(2);
		`CHK(latency_baud_threshold, 24'h000000)
	endtask

	task automatic t_modes;
		logic [7:0] cf [12] = '{8'h03, 8'h0b, 8'h04, 8'h0c, 8'h30, 8'h38,
			8'h50, 8'h58, 8'h20, 8'h05, 8'h01, 8'h02};
		int pn [12] = '{5, 5, 5, 5, 7, 7, 7, 7, 7, 5, 5, 2};
		logic [11:0] eo = 12'h099;
		logic [11:0] ee = 12'hcff;
		logic v;
		@(posedge sys_clk) override_mode <= 1;
		uart_sending <= 1;
		for (int i = 0; i < 12; i++) begin
			wr(12'h009, cf[i]);
			cyc(2);
			`CHK({pin_out[pn[i]], pin_oe[pn[i]]}, {eo[i], ee[i]})
		end
		wr(12'h009, 8'h01);
		@(posedge sys_clk) ext_lvl[4] <= 1;
		cyc(8);
		`CHK(tx_allowed, 1'b0)
		@(posedge sys_clk) ext_lvl[4] <= 0;
		cyc(8);
		`CHK(tx_allowed, 1'b1)
		wr(12'h009, 8'h02);
		@(posedge sys_clk) ext_lvl[3] <= 1;
		cyc(8);
		`CHK({tx_allowed, pin_oe[3]}, 2'b00)
		@(posedge sys_clk) ext_lvl[3] <= 0;
		cyc(8);
		`CHK(tx_allowed, 1'b1)
		wr(12'h009, 8'h80);
		cyc(2);
		`CHK(pin_oe[6], 1'b1)
		v = pin_out[6];
		cyc(3);
		`CHK(pin_out[6], ~v)
		wr(12'h009, 8'h03);
		@(posedge sys_clk) override_mode <= 0;
		cyc(2);
		`CHK(pin_oe[5], 1'b0)
		wr(12'h009, 8'h00);
	endtask

	task automatic t_toggles;
		logic v8;
		logic v9;
		cyc(1);
		`CHK(pin_oe[9:8], 2'b11)
		v8 = pin_out[8];
		v9 = pin_out[9];
		@(posedge sys_clk) tx_char_done <= 1;
		@(posedge sys_clk) tx_char_done <= 0;
		rx_char_done <= 1;
		@(posedge sys_clk) rx_char_done <= 0;
		cyc(2);
		`CHK(pin_out[9:8], {~v9, ~v8})
		@(posedge sys_clk) override_mode <= 1;
		cyc(2);
		`CHK(pin_oe[9:8], 2'b00)
	endtask

	task automatic t_dir;
		@(posedge sys_clk) override_direction <= 1;
		gpio_write <= 10'h201;
		wr(12'h00b, 8'h03);
		wr(12'h00c, 8'h02);
		cyc(2);
		`CHK(pin_oe, 10'h203)
		`CHK(pin_out & pin_oe, 10'h201)
		cyc(6);
		`CHK(gpio_state, 10'h201)
	endtask

	task automatic t_change;
		@(posedge sys_clk) override_direction <= 0;
		override_mask <= 1;
		wr(12'h00d, 8'hfe);
		wr(12'h00e, 8'h00);
		cyc(8);
		n_ev = 0;
		ev_bits = 0;
		@(posedge sys_clk) ext_lvl[1:0] <= 2'b11;
		cyc(8);
		`CHK({n_ev, ev_bits}, {8'h01, 11'h001})
		@(posedge sys_clk) rx_data_pin <= 1;
		cyc(8);
		`CHK(ev_bits, 11'h401)
		wr(12'h00e, 8'h04);
		@(posedge sys_clk) rx_data_pin <= 0;
		cyc(8);
		`CHK(n_ev, 8'h02)
		@(posedge sys_clk) override_mask <= 0;
		ext_lvl[1] <= 0;
		cyc(8);
		`CHK({n_ev, ev_bits}, {8'h03, 11'h403})
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 0;
		t_regs;
		t_thresh;
		t_modes;
		t_toggles;
		t_dir;
		t_change;
		summarize;
	end
endmodule // tb_top

`default_nettype wire
